/* File: core/espb_pkg.sv */
// Package with packet layout, status codes and timing constants of the error packet builder.
package espb_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned GRANT_TIMEOUT_MS = 1000;
    localparam int unsigned XFER_TIMEOUT_MS = 2000;
    localparam int unsigned GRANT_TIMEOUT_CYC = (CLK_HZ / 1000) * GRANT_TIMEOUT_MS;
    localparam int unsigned XFER_TIMEOUT_CYC = (CLK_HZ / 1000) * XFER_TIMEOUT_MS;
    localparam logic [7:0] START_MARKER = 8'h02;
    localparam logic [7:0] END_MARKER = 8'h03;
    localparam logic [7:0] COMPLETION_TYPE = 8'h70;
    localparam logic [7:0] LEN_SHORT = 8'h09;
    localparam logic [7:0] LEN_LONG = 8'h0d;
    localparam logic [15:0] ST_DATA_CHECK = 16'h0001;
    localparam logic [15:0] ST_WRITE_PROT = 16'h0002;
    localparam logic [15:0] ST_NOT_READY = 16'h0003;
    localparam logic [15:0] ST_DELETED = 16'h0004;
    localparam logic [15:0] ST_BAD_UNIT = 16'h0005;
    localparam logic [15:0] ST_BAD_ADDR = 16'h0006;
    localparam logic [15:0] ST_HOME_FAIL = 16'h0007;
    localparam logic [15:0] ST_NOT_FOUND = 16'h0008;
    localparam logic [15:0] ST_HDR_CHECK = 16'h0009;
    localparam logic [15:0] ST_DMA_TIMEOUT = 16'h000a;
    localparam logic [7:0] CMD_READ = 8'h10;
    localparam logic [7:0] CMD_WRITE = 8'h20;
    localparam logic [7:0] CMD_TEST = 8'h30;
    localparam logic [7:0] CMD_CONTROL = 8'h40;
    localparam logic [1:0] SENSE_T0 = 2'h0;
    localparam logic [1:0] SENSE_T1 = 2'h1;
    localparam logic [1:0] SENSE_T2 = 2'h2;
    localparam logic [3:0] SC_NOT_READY = 4'h4;
    localparam logic [3:0] SC_STILL_SEEK = 4'h8;
    localparam logic [3:0] SC_START_BEYOND = 4'h1;
    localparam logic [3:0] SC_END_BEYOND = 4'h3;
    localparam logic [3:0] SC_ID_MISSING = 4'h2;
    localparam logic [3:0] SC_DATA_MISSING = 4'h3;
    localparam logic [3:0] SC_SECTOR_MISSING = 4'h4;
    localparam logic [3:0] FLOPPY_DRIVE_LO = 4'h4;
    localparam logic [3:0] FLOPPY_DRIVE_HI = 4'h7;
    localparam logic [3:0] HARD_CTRL_HI = 4'h7;
    localparam logic [3:0] HARD_DRIVE_HI = 4'h1;
    localparam logic [3:0] TAPE_DRIVE = 4'h4;
    localparam logic [3:0] SHARED_DRIVE = 4'h5;
    localparam logic [3:0] IDX_BLOCK0 = 4'd8;
    localparam logic [3:0] PKT_MAX = 4'd13;
    typedef enum logic [3:0] {
        ESPB_EV_DATA_CHECK, ESPB_EV_WRITE_PROT, ESPB_EV_NOT_READY, ESPB_EV_DELETED,
        ESPB_EV_BAD_ADDR, ESPB_EV_HOME_FAIL, ESPB_EV_NOT_FOUND, ESPB_EV_HDR_CHECK,
        ESPB_EV_NONE
    } espb_event_t;
endpackage : espb_pkg

/* File: core/espb_buf_if.sv */
// Interface carrying the byte write and read paths between the builder and its packet memory.
`timescale 1ns/1ps
`default_nettype none
interface espb_buf_if;
    logic we;
    logic [3:0] waddr;
    logic [7:0] wdata;
    logic [3:0] raddr;
    logic [7:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : espb_buf_if
`default_nettype wire

/* File: core/espb_pkt_mem.sv */
// Sixteen-byte packet memory with registered read data.
`timescale 1ns/1ps
`default_nettype none
module espb_pkt_mem (
    input wire logic sys_clk,
    espb_buf_if.mem bus
);
    import espb_pkg::*;
    logic [7:0] mem_reg [0:15];
    logic [7:0] rdata_reg;
    always_ff @(posedge sys_clk) begin
        if (bus.we) begin
            mem_reg[bus.waddr] <= bus.wdata;
        end
        rdata_reg <= mem_reg[bus.raddr];
    end
    assign bus.rdata = rdata_reg;
endmodule : espb_pkt_mem
`default_nettype wire

/* File: core/espb_builder.sv */
// Error status packet builder: latches the first error of a command and streams its packet.
`timescale 1ns/1ps
`default_nettype none
module espb_builder #(
    parameter int unsigned GRANT_CYC = espb_pkg::GRANT_TIMEOUT_CYC,
    parameter int unsigned XFER_CYC = espb_pkg::XFER_TIMEOUT_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cmd_start,
    input wire logic [7:0] cmd_msg_id,
    input wire logic [3:0] cmd_ctrl,
    input wire logic [3:0] cmd_drive,
    input wire logic [7:0] cmd_type,
    input wire logic [31:0] cmd_block_index,
    input wire logic [31:0] unit_block_count,
    input wire logic unit_is_hard,
    input wire logic unit_is_tape,
    input wire logic cfg_floppy_req,
    input wire logic drive4_is_tape,
    input wire logic drive_selected,
    input wire logic drive_ready,
    input wire logic floppy_no_ready_line,
    input wire logic index_seen,
    input wire logic tape_cart_in,
    input wire logic tape_retention_done,
    input wire logic [3:0] err_event,
    input wire logic [31:0] err_block_index,
    input wire logic sense_valid,
    input wire logic [1:0] sense_type,
    input wire logic [3:0] sense_code,
    input wire logic home_search_fail,
    input wire logic bus_req,
    input wire logic bus_grant,
    input wire logic dma_busy,
    input wire logic cmd_done,
    input wire logic chan_ready,
    output logic dma_abort,
    output logic chan_we,
    output logic [3:0] chan_addr,
    output logic [7:0] chan_data,
    output logic irq_req,
    output logic busy
);
    import espb_pkg::*;

    typedef enum logic [1:0] {ESPB_IDLE, ESPB_RUN, ESPB_FILL, ESPB_SEND} espb_state_t;

    espb_state_t state_reg, state_next;
    logic [7:0] id_reg;
    logic [7:0] unit_reg;
    logic [7:0] type_reg;
    logic [15:0] code_reg;
    logic [31:0] blk_reg;
    logic long_reg;
    logic err_reg;
    logic [3:0] idx_reg;
    logic [31:0] grant_cnt_reg;
    logic [31:0] xfer_cnt_reg;
    logic send_rd_reg;
    logic [3:0] send_idx_reg;
    logic dma_abort_reg, chan_we_reg, irq_reg, busy_reg;
    logic [3:0] chan_addr_reg;
    logic [7:0] chan_data_reg;

    espb_buf_if buf_bus ();
    espb_pkt_mem u_mem (.sys_clk(sys_clk), .bus(buf_bus));

    // Readiness: real ready line, index pulse on floppies without one, tape after retention.
    wire floppy_ready = floppy_no_ready_line ? index_seen : drive_ready;
    wire tape_ready = tape_cart_in & tape_retention_done;
    wire unit_ready = unit_is_hard ? drive_ready : (unit_is_tape ? tape_ready : floppy_ready);
    wire ev_not_ready = drive_selected & ~unit_ready;

    wire sense_nr = sense_valid & (sense_type == SENSE_T0)
        & ((sense_code == SC_NOT_READY) | (sense_code == SC_STILL_SEEK));
    wire sense_addr = sense_valid & (sense_type == SENSE_T2)
        & ((sense_code == SC_START_BEYOND) | (sense_code == SC_END_BEYOND));
    wire sense_nf = sense_valid & (sense_type == SENSE_T1)
        & ((sense_code == SC_ID_MISSING) | (sense_code == SC_DATA_MISSING)
        | (sense_code == SC_SECTOR_MISSING));

    wire hard_unit_ok = (cmd_ctrl <= HARD_CTRL_HI) & (cmd_drive <= HARD_DRIVE_HI);
    wire soft_unit_ok = (cmd_ctrl == 4'h0) & (cmd_drive >= FLOPPY_DRIVE_LO)
        & (cmd_drive <= FLOPPY_DRIVE_HI);
    wire unit_bad = unit_is_hard ? ~hard_unit_ok : ~soft_unit_ok;
    wire cfg_clash = cfg_floppy_req & (cmd_drive == SHARED_DRIVE) & drive4_is_tape;
    wire blk_over = cmd_block_index > unit_block_count;

    wire grant_to = bus_req & ~bus_grant & (grant_cnt_reg >= GRANT_CYC - 1);
    wire xfer_to = dma_busy & (xfer_cnt_reg >= XFER_CYC - 1);

    // Event decode, highest first; the earliest cycle's event is what gets kept.
    logic [15:0] ev_code;
    logic ev_long;
    logic ev_hit;
    always_comb begin
        ev_hit = 1'b1;
        ev_long = 1'b0;
        ev_code = ST_DATA_CHECK;
        if (grant_to | xfer_to) begin
            ev_code = ST_DMA_TIMEOUT;
        end else if (ev_not_ready | sense_nr | (err_event == ESPB_EV_NOT_READY)) begin
            ev_code = ST_NOT_READY;
        end else if (home_search_fail | (err_event == ESPB_EV_HOME_FAIL)) begin
            ev_code = ST_HOME_FAIL;
        end else if (sense_addr | (err_event == ESPB_EV_BAD_ADDR)) begin
            ev_code = ST_BAD_ADDR;
            ev_long = 1'b1;
        end else if (sense_nf | (err_event == ESPB_EV_NOT_FOUND)) begin
            ev_code = ST_NOT_FOUND;
            ev_long = 1'b1;
        end else if (err_event == ESPB_EV_DATA_CHECK) begin
            ev_code = ST_DATA_CHECK;
            ev_long = 1'b1;
        end else if (err_event == ESPB_EV_DELETED) begin
            ev_code = ST_DELETED;
            ev_long = 1'b1;
        end else if (err_event == ESPB_EV_HDR_CHECK) begin
            ev_code = ST_HDR_CHECK;
            ev_long = 1'b1;
        end else if ((err_event == ESPB_EV_WRITE_PROT) & ~unit_is_hard) begin
            ev_code = ST_WRITE_PROT;
        end else begin
            ev_hit = 1'b0;
        end
    end

    wire start_bad = unit_bad | cfg_clash;
    wire take_ev = (state_reg == ESPB_RUN) & ev_hit & ~err_reg;

    // Packet byte selected by write index.
    logic [7:0] fill_byte;
    always_comb begin
        unique case (idx_reg)
            4'd0: fill_byte = START_MARKER;
            4'd1: fill_byte = id_reg;
            4'd2: fill_byte = long_reg ? LEN_LONG : LEN_SHORT;
            4'd3: fill_byte = unit_reg;
            4'd4: fill_byte = type_reg;
            4'd5: fill_byte = COMPLETION_TYPE;
            4'd6: fill_byte = code_reg[15:8];
            4'd7: fill_byte = code_reg[7:0];
            4'd8: fill_byte = long_reg ? blk_reg[31:24] : END_MARKER;
            4'd9: fill_byte = blk_reg[23:16];
            4'd10: fill_byte = blk_reg[15:8];
            4'd11: fill_byte = blk_reg[7:0];
            default: fill_byte = END_MARKER;
        endcase
    end

    wire [3:0] last_idx = long_reg ? (PKT_MAX - 4'd1) : IDX_BLOCK0;
    wire fill_last = idx_reg == last_idx;
    wire send_step = (state_reg == ESPB_SEND) & chan_ready;
    wire send_last = send_rd_reg & (send_idx_reg == last_idx) & chan_ready;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ESPB_IDLE: if (cmd_start) state_next = start_bad ? ESPB_FILL : ESPB_RUN;
            ESPB_RUN: if (cmd_done | xfer_to | grant_to) state_next = ESPB_FILL;
            ESPB_FILL: if (fill_last) state_next = ESPB_SEND;
            ESPB_SEND: if (send_last) state_next = ESPB_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_reg <= ESPB_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Command capture and first-error latch.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            id_reg <= 8'h00;
            unit_reg <= 8'h00;
            type_reg <= 8'h00;
            code_reg <= 16'h0000;
            blk_reg <= 32'h0000_0000;
            long_reg <= 1'b0;
            err_reg <= 1'b0;
        end else if ((state_reg == ESPB_IDLE) & cmd_start) begin
            id_reg <= cmd_msg_id;
            unit_reg <= {cmd_ctrl, cmd_drive};
            type_reg <= cmd_type;
            blk_reg <= cmd_block_index;
            long_reg <= 1'b0;
            err_reg <= start_bad;
            code_reg <= start_bad ? ST_BAD_UNIT : 16'h0000;
        end else if ((state_reg == ESPB_RUN) & ~err_reg & blk_over) begin
            code_reg <= ST_BAD_ADDR;
            long_reg <= 1'b1;
            err_reg <= 1'b1;
        end else if (take_ev) begin
            code_reg <= ev_code;
            long_reg <= ev_long;
            blk_reg <= ev_long ? err_block_index : blk_reg;
            err_reg <= 1'b1;
        end
    end

    // Bus grant and transfer watchdogs.
    always_ff @(posedge sys_clk) begin
        if (!rstn | (state_reg != ESPB_RUN)) begin
            grant_cnt_reg <= 32'h0;
            xfer_cnt_reg <= 32'h0;
        end else begin
            grant_cnt_reg <= (bus_req & ~bus_grant) ? grant_cnt_reg + 32'h1 : 32'h0;
            xfer_cnt_reg <= dma_busy ? xfer_cnt_reg + 32'h1 : 32'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn | (state_reg == ESPB_IDLE)) begin
            idx_reg <= 4'h0;
        end else if (state_reg == ESPB_FILL) begin
            idx_reg <= fill_last ? 4'h0 : idx_reg + 4'h1;
        end
    end

    assign buf_bus.we = state_reg == ESPB_FILL;
    assign buf_bus.waddr = idx_reg;
    assign buf_bus.wdata = fill_byte;
    assign buf_bus.raddr = send_step ? (send_rd_reg ? send_idx_reg + 4'h1 : 4'h0) : send_idx_reg;

    // Streaming out: memory read data is one cycle behind its address.
    always_ff @(posedge sys_clk) begin
        if (!rstn | (state_reg != ESPB_SEND)) begin
            send_rd_reg <= 1'b0;
            send_idx_reg <= 4'h0;
        end else if (chan_ready) begin
            send_rd_reg <= 1'b1;
            send_idx_reg <= send_rd_reg ? send_idx_reg + 4'h1 : 4'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            chan_we_reg <= 1'b0;
            chan_addr_reg <= 4'h0;
            chan_data_reg <= 8'h00;
            irq_reg <= 1'b0;
            dma_abort_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            chan_we_reg <= send_rd_reg & chan_ready & (state_reg == ESPB_SEND);
            chan_addr_reg <= send_idx_reg;
            chan_data_reg <= buf_bus.rdata;
            irq_reg <= chan_we_reg & (chan_addr_reg == last_idx) & (state_reg == ESPB_IDLE);
            dma_abort_reg <= (state_reg == ESPB_RUN) & (grant_to | xfer_to);
            busy_reg <= state_next != ESPB_IDLE;
        end
    end

    assign chan_we = chan_we_reg;
    assign chan_addr = chan_addr_reg;
    assign chan_data = chan_data_reg;
    assign irq_req = irq_reg;
    assign dma_abort = dma_abort_reg;
    assign busy = busy_reg;
endmodule : espb_builder
`default_nettype wire

/* File: verification/espb_builder_sva.sv */
// Checker on the channel stream of the error packet builder.
`timescale 1ns/1ps
`default_nettype none
module espb_builder_sva (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cmd_start,
    input wire logic chan_we,
    input wire logic [3:0] chan_addr,
    input wire logic [7:0] chan_data,
    input wire logic irq_req,
    input wire logic busy
);
    import espb_pkg::*;
    logic [3:0] len_reg;
    logic [3:0] last_reg;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            len_reg <= 4'h0;
            last_reg <= 4'h0;
        end else if (chan_we) begin
            last_reg <= chan_addr;
            if (chan_addr == 4'h2) begin
                len_reg <= chan_data[3:0];
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence last_byte;
        chan_we && chan_addr == len_reg - 4'h1;
    endsequence
    a_start_marker: assert property (chan_we && chan_addr == 4'h0 |-> chan_data == START_MARKER)
        else $error("first byte is not the start marker");
    a_end_marker: assert property (last_byte |-> chan_data == END_MARKER)
        else $error("last byte is not the end marker");
    a_len_legal: assert property (chan_we && chan_addr == 4'h2 |-> chan_data inside {8'h09, 8'h0d})
        else $error("bad packet length byte");
    a_compl_type: assert property (chan_we && chan_addr == 4'h5 |-> chan_data == 8'h70)
        else $error("bad completion type byte");
    a_irq_after_last: assert property (last_byte |=> irq_req)
        else $error("no interrupt after the last byte");
    a_irq_cause: assert property (irq_req |-> $past(chan_we) && $past(chan_addr) == len_reg - 4'h1)
        else $error("interrupt without a finished packet");
    a_irq_pulse: assert property (irq_req |=> !irq_req)
        else $error("interrupt longer than one cycle");
    a_addr_step: assert property (chan_we && chan_addr != 4'h0 |-> chan_addr == last_reg + 4'h1)
        else $error("packet bytes out of order");
    a_start_busy: assert property (cmd_start && !busy |=> busy)
        else $error("command not taken");
endmodule : espb_builder_sva
bind espb_builder espb_builder_sva espb_builder_sva_i (.sys_clk, .rstn, .cmd_start, .chan_we,
    .chan_addr, .chan_data, .irq_req, .busy);
`default_nettype wire

/* File: verification/espb_host_model.sv */
// Host side of the command channel: takes packet bytes, optionally stalling.
`timescale 1ns/1ps
`default_nettype none
module espb_host_model (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic stall,
    input wire logic chan_we,
    input wire logic [3:0] chan_addr,
    input wire logic [7:0] chan_data,
    output logic chan_ready,
    output logic [103:0] pkt,
    output logic [3:0] nbytes
);
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            chan_ready <= 1'b0;
            pkt <= '0;
            nbytes <= 4'h0;
        end else begin
            // A stalling host accepts only every other cycle.
            chan_ready <= !stall || !chan_ready;
            if (chan_we) begin
                pkt[8*chan_addr +: 8] <= chan_data;
                nbytes <= chan_addr + 4'h1;
            end
        end
    end
endmodule : espb_host_model
`default_nettype wire

/* File: verification/tb_espb_builder.sv */
// Self-checking testbench of the error packet builder.
`timescale 1ns/1ps
`default_nettype none
module tb_espb_builder;
    import espb_pkg::*;
    logic sys_clk = 1'b0, rstn = 1'b0, cmd_start = 1'b0, cmd_done = 1'b0, sense_valid = 1'b0;
    logic home_search_fail = 1'b0, unit_is_hard = 1'b0, unit_is_tape = 1'b0, cfg_floppy_req = 1'b0;
    logic drive4_is_tape = 1'b1, drive_selected = 1'b0, drive_ready = 1'b1, index_seen = 1'b0;
    logic floppy_no_ready_line = 1'b0, tape_cart_in = 1'b1, tape_retention_done = 1'b1;
    logic bus_req = 1'b0, bus_grant = 1'b1, dma_busy = 1'b0, stall = 1'b0, saw_abort = 1'b0;
    logic chan_ready, chan_we, irq_req, busy, dma_abort;
    logic [7:0] cmd_msg_id = 8'h20, cmd_type = 8'h10, chan_data;
    logic [3:0] cmd_ctrl = 4'h0, cmd_drive = 4'h6, err_event = 4'hf, sense_code = 4'h0;
    logic [3:0] chan_addr, nbytes;
    logic [1:0] sense_type = 2'h0;
    logic [31:0] cmd_block_index = 32'h123, unit_block_count = 32'h1000, err_block_index = 32'ha5c;
    logic [103:0] pkt;
    int bad_count = 0, n_tests = 0, cyc = 0;
    espb_builder #(.GRANT_CYC(20), .XFER_CYC(40)) espb_builder_i (.sys_clk, .rstn, .cmd_start,
        .cmd_msg_id, .cmd_ctrl, .cmd_drive, .cmd_type, .cmd_block_index, .unit_block_count,
        .unit_is_hard, .unit_is_tape, .cfg_floppy_req, .drive4_is_tape, .drive_selected,
        .drive_ready, .floppy_no_ready_line, .index_seen, .tape_cart_in, .tape_retention_done,
        .err_event, .err_block_index, .sense_valid, .sense_type, .sense_code, .home_search_fail,
        .bus_req, .bus_grant, .dma_busy, .cmd_done, .chan_ready, .dma_abort, .chan_we,
        .chan_addr, .chan_data, .irq_req, .busy);
    espb_host_model espb_host_model_i (.sys_clk, .rstn, .stall, .chan_we, .chan_addr,
        .chan_data, .chan_ready, .pkt, .nbytes);
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        // Each new command clears the record of a watchdog abort.
        if (cmd_start === 1'b1) begin
            saw_abort <= 1'b0;
        end else if (dma_abort === 1'b1) begin
            saw_abort <= 1'b1;
        end
        if (cyc == 10000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    // Starts a command, applies up to two events in its first run cycles, waits for the packet.
    task automatic run(input logic [3:0] ev, input logic [3:0] ev2, input logic sv,
            input logic [5:0] sn, input logic hf, input logic fin);
        int n;
        repeat (3) @(posedge sys_clk);
        cmd_msg_id <= cmd_msg_id + 8'h11;
        cmd_start <= 1'b1;
        @(posedge sys_clk);
        cmd_start <= 1'b0;
        err_event <= ev;
        {sense_valid, sense_type, sense_code, home_search_fail} <= {sv, sn, hf};
        @(posedge sys_clk);
        err_event <= ev2;
        {sense_valid, home_search_fail} <= 2'b00;
        @(posedge sys_clk);
        err_event <= 4'hf;
        cmd_done <= fin;
        @(posedge sys_clk);
        cmd_done <= 1'b0;
        // The interrupt is looked at between edges, where it stands settled.
        for (n = 0; n < 300 && irq_req !== 1'b1; n++) @(negedge sys_clk);
        chk8({7'h0, irq_req}, 8'h01);
        @(posedge sys_clk);
    endtask : run
    task automatic expect_pkt(input logic [15:0] code, input logic [31:0] bi);
        logic [7:0] e [13];
        int len;
        len = (code inside {16'h1, 16'h4, 16'h6, 16'h8, 16'h9}) ? 13 : 9;
        e = '{8'h02, cmd_msg_id, len[7:0], {cmd_ctrl, cmd_drive}, cmd_type, 8'h70, code[15:8],
            code[7:0], bi[31:24], bi[23:16], bi[15:8], bi[7:0], 8'h03};
        e[len-1] = 8'h03;
        chk8({4'h0, nbytes}, len[7:0]);
        for (int i = 0; i < len; i++) chk8(pkt[8*i +: 8], e[i]);
    endtask : expect_pkt
    task automatic t_events();
        logic [15:0] c [9] = '{16'h1, 16'h2, 16'h3, 16'h4, 16'h6, 16'h7, 16'h8, 16'h9, 16'h0};
        for (int i = 0; i < 9; i++) begin
            cmd_type <= 8'h10 + 8'(i % 4) * 8'h10;
            run(4'(i), 4'hf, 1'b0, 6'h0, 1'b0, 1'b1);
            expect_pkt(c[i], err_block_index);
        end
        run(4'hf, 4'hf, 1'b0, 6'h0, 1'b1, 1'b1);
        expect_pkt(16'h7, 32'h0);
        run(4'h7, 4'h0, 1'b0, 6'h0, 1'b0, 1'b1);
        expect_pkt(16'h9, err_block_index);
    endtask : t_events
    task automatic t_sense();
        logic [5:0] s [7] = '{6'h04, 6'h08, 6'h21, 6'h23, 6'h12, 6'h13, 6'h14};
        logic [15:0] c [7] = '{16'h3, 16'h3, 16'h6, 16'h6, 16'h8, 16'h8, 16'h8};
        {unit_is_hard, cmd_ctrl, cmd_drive, stall} <= {1'b1, 4'h7, 4'h1, 1'b1};
        err_block_index <= cmd_block_index;
        for (int i = 0; i < 7; i++) begin
            run(4'hf, 4'hf, 1'b1, s[i], 1'b0, 1'b1);
            expect_pkt(c[i], cmd_block_index);
        end
        run(4'h1, 4'hf, 1'b0, 6'h0, 1'b0, 1'b1);
        expect_pkt(16'h0, 32'h0);
        {unit_is_hard, cmd_ctrl, cmd_drive, stall} <= {1'b0, 4'h0, 4'h6, 1'b0};
    endtask : t_sense
    task automatic t_units();
        logic [10:0] u [8] = '{11'h414, 11'h403, 11'h408, 11'h602, 11'h680, 11'h505, 11'h007,
            11'h271};
        for (int i = 0; i < 8; i++) begin
            {unit_is_hard, cfg_floppy_req, cmd_ctrl, cmd_drive} <= u[i][9:0];
            run(4'hf, 4'hf, 1'b0, 6'h0, 1'b0, 1'b1);
            expect_pkt(u[i][10] ? 16'h5 : 16'h0, 32'h0);
        end
        {unit_is_hard, cfg_floppy_req, cmd_ctrl, cmd_drive} <= {2'b00, 4'h0, 4'h6};
    endtask : t_units
    task automatic t_ready();
        logic [5:0] r [6] = '{6'h20, 6'h0c, 6'h28, 6'h32, 6'h13, 6'h31};
        {drive_selected, drive_ready} <= 2'b10;
        for (int i = 0; i < 6; i++) begin
            {unit_is_tape, floppy_no_ready_line, index_seen, tape_cart_in} <= r[i][4:1];
            tape_retention_done <= r[i][0];
            cmd_drive <= r[i][4] ? 4'h4 : 4'h6;
            run(4'hf, 4'hf, 1'b0, 6'h0, 1'b0, 1'b1);
            expect_pkt(r[i][5] ? 16'h3 : 16'h0, 32'h0);
        end
        {drive_selected, drive_ready, unit_is_tape, cmd_drive} <= {3'b010, 4'h6};
    endtask : t_ready
    task automatic t_overflow();
        cmd_block_index <= unit_block_count + 32'h1;
        run(4'hf, 4'hf, 1'b0, 6'h0, 1'b0, 1'b1);
        expect_pkt(16'h6, cmd_block_index);
        cmd_block_index <= unit_block_count;
        run(4'hf, 4'hf, 1'b0, 6'h0, 1'b0, 1'b1);
        expect_pkt(16'h0, 32'h0);
    endtask : t_overflow
    task automatic t_watchdog();
        for (int i = 0; i < 2; i++) begin
            {bus_req, bus_grant, dma_busy} <= (i == 0) ? 3'b100 : 3'b011;
            run(4'hf, 4'hf, 1'b0, 6'h0, 1'b0, 1'b0);
            expect_pkt(16'ha, 32'h0);
            chk8({7'h0, saw_abort}, 8'h01);
        end
        {bus_req, bus_grant, dma_busy} <= 3'b010;
    endtask : t_watchdog
    // Resets in the middle of a command: nothing of it may come out afterwards.
    task automatic t_reset();
        cmd_start <= 1'b1;
        @(posedge sys_clk);
        cmd_start <= 1'b0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b0;
        @(posedge sys_clk);
        rstn <= 1'b1;
        @(negedge sys_clk);
        chk8({4'h0, chan_we, irq_req, busy, dma_abort}, 8'h00);
        @(posedge sys_clk);
        run(4'hf, 4'hf, 1'b0, 6'h0, 1'b0, 1'b1);
        expect_pkt(16'h0, 32'h0);
    endtask : t_reset
    initial begin
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        t_events();
        t_sense();
        t_units();
        t_ready();
        t_overflow();
        t_watchdog();
        t_reset();
        close_out();
    end
endmodule : tb_espb_builder
`default_nettype wire
